// >>> ses_pkg.sv
// Package of the serial EEPROM slave: geometry, select codes, states, timing.
// Assumes a single 100 MHz system clock that samples the two-wire pins.

package ses_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ARRAY_BYTES = 2048;
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_W = 11;
  localparam int COL_W = 4;
  localparam int LOCK_BIT = 7;
  localparam int BUF_DEPTH = 2;

  // ---------------------------------------------------------------
  // Select byte codes, top nibble, and bits per byte
  // ---------------------------------------------------------------
  localparam logic [3:0] SEL_MAIN = 4'hA;
  localparam logic [3:0] SEL_ID = 4'hB;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_PROG_MS = 5;
  localparam int SCL_MAX_KHZ = 1000;
  // Longest time rounds down
  localparam int PROG_CYCLES = T_PROG_MS * 1000000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_DEV = 9'h002,
    ST_ACK_DEV = 9'h004,
    ST_ADDR = 9'h008,
    ST_ACK_ADDR = 9'h010,
    ST_DATA_W = 9'h020,
    ST_ACK_W = 9'h040,
    ST_DATA_R = 9'h080,
    ST_ACK_R = 9'h100
  } ses_state_t;

  typedef struct packed {
    logic [COL_W-1:0] col;
    logic [7:0] data;
  } ses_wr_t;

endpackage

// >>> ses_buf.sv
// Two-entry style buffer with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module ses_buf #(
  parameter int W = 12,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slot;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] count;
  } ses_buf_t;

  ses_buf_t cur;
  ses_buf_t next_cur;
  logic do_in;
  logic do_out;

  assign in_ready = (cur.count != CW'(DEPTH));
  assign out_valid = (cur.count != '0);
  assign out_data = cur.slot[cur.rp];
  assign do_in = in_valid && in_ready;
  assign do_out = out_valid && out_ready;

  always_comb begin
    next_cur = cur;
    if (do_in) begin
      next_cur.slot[cur.wp] = in_data;
      next_cur.wp = (cur.wp == PW'(DEPTH - 1)) ? '0 : PW'(cur.wp + 1'b1);
    end
    if (do_out) begin
      next_cur.rp = (cur.rp == PW'(DEPTH - 1)) ? '0 : PW'(cur.rp + 1'b1);
    end
    if (do_in && !do_out) begin
      next_cur.count = CW'(cur.count + 1'b1);
    end else if (do_out && !do_in) begin
      next_cur.count = CW'(cur.count - 1'b1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

endmodule

`default_nettype wire

// >>> ses_eeprom.sv
// Serial EEPROM slave core: two-wire bit engine, page latch, self-timed
// programming, write protect and lockable identification page.
// Assumes SCL/SDA already synchronous to CLOCK, SDA resolved outside.
`timescale 1ns/1ns
`default_nettype none

module ses_eeprom #(
  parameter int PROG_CYCLES = ses_pkg::PROG_CYCLES,
  parameter bit HAS_ID_PAGE = 1'b1
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic WP,
  output logic STANDBY
);

  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam int AW = ses_pkg::ADDR_W;
  localparam int CW = ses_pkg::COL_W;
  localparam int BW = CW + 8;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ses_pkg::ses_state_t state;
    logic scl_q;
    logic sda_q;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic sda_oe;
    logic is_id;
    logic rd;
    logic more;
    logic lock_req;
    logic busy;
    logic [TW-1:0] timer;
    logic [AW-1:0] addr;
    logic [AW-CW-1:0] pg_base;
    logic pg_id;
    logic [ses_pkg::PAGE_BYTES-1:0] mask;
    logic [ses_pkg::PAGE_BYTES-1:0][7:0] pg;
  } ses_core_t;

  // Non-volatile contents survive every reset
  typedef struct packed {
    logic lock;
    logic [ses_pkg::PAGE_BYTES-1:0][7:0] idp;
    logic [ses_pkg::ARRAY_BYTES-1:0][7:0] mem;
  } ses_nv_t;

  ses_core_t cur;
  ses_core_t next_cur;
  ses_nv_t nv = '{lock: 1'b0, idp: '1, mem: '1};
  ses_nv_t next_nv;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic rx_state;
  logic byte_done_w;
  logic [7:0] rd_byte;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  ses_pkg::ses_wr_t buf_in;
  ses_pkg::ses_wr_t buf_out;

  // ---------------------------------------------------------------
  // Pin events
  // ---------------------------------------------------------------
  // At 100 MHz each 1 MHz SCL phase gives dozens of samples
  assign scl_rise = SCL && !cur.scl_q;
  assign scl_fall = !SCL && cur.scl_q;
  assign start_det = SCL && cur.scl_q && cur.sda_q && !SDA_IN;
  assign stop_det = SCL && cur.scl_q && !cur.sda_q && SDA_IN;
  assign rx_state = (cur.state == ses_pkg::ST_DEV) || (cur.state == ses_pkg::ST_ADDR) ||
                    (cur.state == ses_pkg::ST_DATA_W);
  assign byte_done_w = (cur.state == ses_pkg::ST_DATA_W) && scl_fall && !cur.busy &&
                       !start_det && !stop_det && (cur.cnt == ses_pkg::BITS_PER_BYTE);
  assign rd_byte = cur.is_id ? nv.idp[cur.addr[CW-1:0]] : nv.mem[cur.addr];

  assign SDA_OUT = 1'b0;
  assign SDA_OE = cur.sda_oe;
  assign STANDBY = (cur.state == ses_pkg::ST_IDLE) && !cur.busy;

  // ---------------------------------------------------------------
  // Write buffer between bit engine and page latch
  // ---------------------------------------------------------------
  assign buf_in_valid = byte_done_w && !cur.lock_req;
  assign buf_in.col = cur.addr[CW-1:0];
  assign buf_in.data = cur.shreg;

  ses_buf #(.W(BW), .DEPTH(ses_pkg::BUF_DEPTH)) u_buf (
    .clk(CLOCK),
    .rst(RST),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in),
    .out_valid(buf_out_valid),
    .out_ready(!cur.busy),
    .out_data(buf_out)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic load_rd;
    load_rd = 1'b0;
    next_cur = cur;
    next_nv = nv;
    next_cur.scl_q = SCL;
    next_cur.sda_q = SDA_IN;
    if (buf_out_valid && !cur.busy) begin
      next_cur.pg[buf_out.col] = buf_out.data;
      next_cur.mask[buf_out.col] = 1'b1;
    end
    if (cur.busy) begin
      // Bus is ignored entirely while programming
      if (cur.timer == '0) begin
        next_cur.busy = 1'b0;
        for (int i = 0; i < ses_pkg::PAGE_BYTES; i++) begin
          if (cur.mask[i]) begin
            if (cur.pg_id) begin
              next_nv.idp[i] = cur.pg[i];
            end else begin
              next_nv.mem[{cur.pg_base, CW'(i)}] = cur.pg[i];
            end
          end
        end
        if (cur.lock_req) begin
          next_nv.lock = 1'b1;
        end
        next_cur.mask = '0;
        next_cur.lock_req = 1'b0;
      end else begin
        next_cur.timer = TW'(cur.timer - 1'b1);
      end
    end else if (start_det) begin
      next_cur.state = ses_pkg::ST_DEV;
      next_cur.cnt = '0;
      next_cur.sda_oe = 1'b0;
    end else if (stop_det) begin
      next_cur.state = ses_pkg::ST_IDLE;
      next_cur.sda_oe = 1'b0;
      if ((|cur.mask || cur.lock_req) && !WP && !(cur.pg_id && nv.lock)) begin
        next_cur.busy = 1'b1;
        next_cur.timer = TW'(PROG_CYCLES - 1);
      end else begin
        next_cur.mask = '0;
        next_cur.lock_req = 1'b0;
      end
    end else begin
      if (rx_state && scl_rise) begin
        next_cur.shreg = {cur.shreg[6:0], SDA_IN};
        next_cur.cnt = cur.cnt + 4'h1;
      end
      case (cur.state)
        ses_pkg::ST_IDLE: begin
        end
        ses_pkg::ST_DEV: begin
          if (scl_fall && cur.cnt == ses_pkg::BITS_PER_BYTE) begin
            next_cur.cnt = '0;
            if (cur.shreg[7:4] == ses_pkg::SEL_MAIN ||
                (HAS_ID_PAGE && cur.shreg[7:4] == ses_pkg::SEL_ID)) begin
              next_cur.sda_oe = 1'b1;
              next_cur.state = ses_pkg::ST_ACK_DEV;
              next_cur.is_id = (cur.shreg[7:4] == ses_pkg::SEL_ID);
              next_cur.rd = cur.shreg[0];
              if (cur.shreg[7:4] == ses_pkg::SEL_MAIN) begin
                next_cur.addr[AW-1:8] = cur.shreg[3:1];
              end
              if (!cur.shreg[0]) begin
                next_cur.mask = '0;
                next_cur.lock_req = 1'b0;
                next_cur.pg_id = (cur.shreg[7:4] == ses_pkg::SEL_ID);
              end
            end else begin
              next_cur.state = ses_pkg::ST_IDLE;
            end
          end
        end
        ses_pkg::ST_ACK_DEV: begin
          if (scl_fall) begin
            if (cur.rd) begin
              load_rd = 1'b1;
            end else begin
              next_cur.sda_oe = 1'b0;
              next_cur.state = ses_pkg::ST_ADDR;
            end
          end
        end
        ses_pkg::ST_ADDR: begin
          if (scl_fall && cur.cnt == ses_pkg::BITS_PER_BYTE) begin
            next_cur.cnt = '0;
            next_cur.sda_oe = 1'b1;
            next_cur.state = ses_pkg::ST_ACK_ADDR;
            next_cur.addr[7:0] = cur.shreg;
            next_cur.pg_base = {cur.addr[AW-1:8], cur.shreg[7:CW]};
            if (cur.is_id && !cur.rd && cur.shreg[ses_pkg::LOCK_BIT]) begin
              next_cur.lock_req = 1'b1;
            end
          end
        end
        ses_pkg::ST_ACK_ADDR, ses_pkg::ST_ACK_W: begin
          if (scl_fall) begin
            next_cur.sda_oe = 1'b0;
            next_cur.state = ses_pkg::ST_DATA_W;
          end
        end
        ses_pkg::ST_DATA_W: begin
          if (byte_done_w) begin
            next_cur.cnt = '0;
            if (buf_in_ready) begin
              next_cur.sda_oe = 1'b1;
              next_cur.state = ses_pkg::ST_ACK_W;
              next_cur.addr[CW-1:0] = cur.addr[CW-1:0] + 4'h1;
            end else begin
              next_cur.state = ses_pkg::ST_IDLE;
            end
          end
        end
        ses_pkg::ST_DATA_R: begin
          if (scl_rise) begin
            next_cur.cnt = cur.cnt + 4'h1;
          end else if (scl_fall) begin
            if (cur.cnt == ses_pkg::BITS_PER_BYTE) begin
              next_cur.sda_oe = 1'b0;
              next_cur.state = ses_pkg::ST_ACK_R;
            end else begin
              next_cur.sda_oe = !cur.shreg[3'(4'h7 - cur.cnt)];
            end
          end
        end
        ses_pkg::ST_ACK_R: begin
          if (scl_rise) begin
            next_cur.more = !SDA_IN;
          end else if (scl_fall) begin
            if (cur.more) begin
              load_rd = 1'b1;
            end else begin
              next_cur.state = ses_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          next_cur.state = ses_pkg::ST_IDLE;
          next_cur.sda_oe = 1'b0;
        end
      endcase
      if (load_rd) begin
        next_cur.shreg = rd_byte;
        next_cur.sda_oe = !rd_byte[7];
        next_cur.cnt = '0;
        next_cur.state = ses_pkg::ST_DATA_R;
        if (cur.is_id) begin
          next_cur.addr[CW-1:0] = cur.addr[CW-1:0] + 4'h1;
        end else begin
          next_cur.addr = cur.addr + 11'h001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cur <= '0;
      cur.state <= ses_pkg::ST_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  always_ff @(posedge CLOCK) begin
    nv <= next_nv;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  int busy_len;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      busy_len <= 0;
    end else begin
      busy_len <= cur.busy ? busy_len + 1 : 0;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  property p_busy_quiet;
    cur.busy |-> !cur.sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("Drive while programming");

  property p_prog_len;
    $fell(cur.busy) |-> busy_len == PROG_CYCLES;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("Program time wrong");

  property p_wp_block;
    $rose(cur.busy) |-> !$past(WP);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("Program under protect");

  property p_stop_idle;
    (stop_det && !cur.busy) |=> cur.state == ses_pkg::ST_IDLE && !cur.sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Stop not honoured");

  property p_idle_quiet;
    cur.state == ses_pkg::ST_IDLE |-> !cur.sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Drive in standby");

  property p_lock_keeps;
    nv.lock |=> nv.lock;
  endproperty
  a_lock_keeps: assert property (p_lock_keeps) else $error("Lock lost");

  property p_locked_id;
    $rose(cur.busy) |-> !(cur.pg_id && nv.lock);
  endproperty
  a_locked_id: assert property (p_locked_id) else $error("Locked page programmed");

  property p_page_wrap;
    (byte_done_w && buf_in_ready) |=>
      cur.addr[AW-1:CW] == $past(cur.addr[AW-1:CW]) &&
      cur.addr[CW-1:0] == $past(cur.addr[CW-1:0]) + 4'h1;
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("Page pointer wrong");

  property p_sel_ack;
    cur.state == ses_pkg::ST_ACK_DEV |-> cur.shreg[7:5] == 3'b101 && cur.sda_oe;
  endproperty
  a_sel_ack: assert property (p_sel_ack) else $error("Bad select acked");

  c_prog: cover property ($fell(cur.busy));
  c_read: cover property (cur.state == ses_pkg::ST_ACK_R);
  c_lock: cover property ($rose(nv.lock));
  c_nack_sel: cover property (cur.state == ses_pkg::ST_DEV ##1 cur.state == ses_pkg::ST_IDLE);

endmodule

`default_nettype wire

// >>> ses_master.sv
// Two-wire bus master model that drives SCL and pulls SDA low.
// Assumes the bench resolves SDA with a pull-up and shares the core clock.
`timescale 1ns/1ns
`default_nettype none

module ses_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // Half period in cycles; 50 keeps SCL at 1 MHz, larger runs slower
  int h = 50;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    sda_pull = 1'b0;
    gap(h);
    scl = 1'b1;
    gap(h);
    sda_pull = 1'b1;
    gap(h);
    scl = 1'b0;
    gap(1);
  endtask

  // Stop: SDA rises while SCL is high, line then left to the pull-up
  task automatic stop();
    sda_pull = 1'b1;
    gap(h);
    scl = 1'b1;
    gap(h);
    sda_pull = 1'b0;
  endtask

  // Nine bit times, MSB first; a 1 releases SDA, last bit is the ACK slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_pull = ~tx[i];
      gap(h);
      scl = 1'b1;
      gap(h);
      rx[i] = sda;
      scl = 1'b0;
      gap(1);
    end
  endtask
endmodule

`default_nettype wire

// >>> ses_eeprom_test.sv
// Self-checking bench of the serial EEPROM slave core.
// Assumes ses_master as bus master and a pull-up on the SDA wire.
`timescale 1ns/1ns
`default_nettype none

module ses_eeprom_test;
  localparam int PROG = 3000;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic WP = 1'b0;
  logic SCL;
  logic pull;
  logic SDA_OUT;
  logic SDA_OE;
  logic STANDBY;
  wire sda_line;
  logic [8:0] rx;
  int errors = 0;
  int total_checks = 0;

  // Open-drain wire with pull-up
  assign sda_line = ~(SDA_OE | pull);

  always #(ses_pkg::CLK_PERIOD_NS / 2) CLOCK = ~CLOCK;

  ses_eeprom #(.PROG_CYCLES(PROG), .HAS_ID_PAGE(1'b1)) dut (.CLOCK(CLOCK), .RST(RST),
    .SCL(SCL), .SDA_IN(sda_line), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .WP(WP),
    .STANDBY(STANDBY));

  ses_master m (.clk(CLOCK), .sda(sda_line), .scl(SCL), .sda_pull(pull));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic ack);
    m.xfer({b, 1'b1}, rx);
    check("ack", 32'(!rx[0]), 32'(ack));
  endtask

  // Checks the standby level just after a stop, then waits for standby
  task automatic wait_idle(input logic busy, output int n);
    n = 2;
    repeat (2) @(negedge CLOCK);
    check("standby after stop", 32'(STANDBY), 32'(!busy));
    while (STANDBY !== 1'b1) begin
      @(negedge CLOCK);
      n++;
      if (n > PROG + 100) begin
        check("standby timeout", 0, 1);
        summarize();
      end
    end
  endtask

  task automatic wr(input logic [3:0] top, input logic [10:0] a, input int n,
                    input logic [31:0] d);
    m.start();
    send({top, a[10:8], 1'b0}, 1'b1);
    send(a[7:0], 1'b1);
    for (int k = 0; k < n; k++) begin
      send(d[31 - 8 * k -: 8], 1'b1);
    end
    m.stop();
  endtask

  // Random read: dummy write sets the pointer, repeated start turns round
  task automatic rd(input logic [3:0] top, input logic [10:0] a, input int n,
                    input logic [31:0] e);
    m.start();
    send({top, a[10:8], 1'b0}, 1'b1);
    send(a[7:0], 1'b1);
    m.start();
    send({top, a[10:8], 1'b1}, 1'b1);
    for (int k = 0; k < n; k++) begin
      m.xfer({8'hFF, k == n - 1}, rx);
      check("read data", 32'(rx[8:1]), 32'(e[31 - 8 * k -: 8]));
    end
    m.stop();
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    RST = 1'b1;
    m.start();
    send(8'hA0, 1'b0);
    m.stop();
    check("sda out", 32'(SDA_OUT), 0);
    RST = 1'b0;
    repeat (2) @(negedge CLOCK);
    check("standby after reset", 32'(STANDBY), 1);
    m.start();
    send(8'hA0, 1'b1);
    RST = 1'b1;
    @(negedge CLOCK);
    check("oe in reset", 32'(SDA_OE), 0);
    check("standby in reset", 32'(STANDBY), 1);
    RST = 1'b0;
    m.stop();
    $display("test reset done");
  endtask

  task automatic test_write();
    int n;
    wr(ses_pkg::SEL_MAIN, 11'h33E, 3, 32'h11223300);
    wait_idle(1'b1, n);
    check("program time", 32'(n >= PROG - 1 && n <= PROG + 3), 1);
    rd(ses_pkg::SEL_MAIN, 11'h33E, 3, 32'h1122FF00);
    rd(ses_pkg::SEL_MAIN, 11'h330, 2, 32'h33FF0000);
    wait_idle(1'b0, n);
    $display("test write done");
  endtask

  task automatic test_protect();
    int n;
    WP = 1'b1;
    wr(ses_pkg::SEL_MAIN, 11'h000, 1, 32'h5A000000);
    wait_idle(1'b0, n);
    WP = 1'b0;
    rd(ses_pkg::SEL_MAIN, 11'h000, 1, 32'hFF000000);
    $display("test protect done");
  endtask

  task automatic test_id();
    int n;
    m.h = 80;
    wr(ses_pkg::SEL_ID, 11'h002, 1, 32'h77000000);
    wait_idle(1'b1, n);
    rd(ses_pkg::SEL_ID, 11'h002, 1, 32'h77000000);
    wr(ses_pkg::SEL_ID, 11'h080, 0, 32'h0);
    m.start();
    send(8'hA0, 1'b0);
    m.stop();
    wait_idle(1'b1, n);
    wr(ses_pkg::SEL_ID, 11'h002, 1, 32'h00000000);
    wait_idle(1'b0, n);
    rd(ses_pkg::SEL_ID, 11'h002, 1, 32'h77000000);
    m.start();
    send(8'h90, 1'b0);
    m.stop();
    m.h = 50;
    $display("test id page done");
  endtask

  initial begin
    repeat (10) @(negedge CLOCK);
    RST = 1'b0;
    repeat (2) @(negedge CLOCK);
    test_reset();
    test_write();
    test_protect();
    test_id();
    summarize();
  end
endmodule

`default_nettype wire
